// ==== design/irw_pkg.sv ====
/*
 Package for the immediate I/O word refresh block: register map, field
 positions, address areas, timing counts, state codes and carried structs.
 Assumes a 100 MHz pclk and a 32-bit APB register bus.
*/
package irw_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_START  = 8'h04;
   localparam logic [7:0] OFS_END    = 8'h08;
   localparam logic [7:0] OFS_UNIT   = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;

   localparam int CTRL_COND = 0;
   localparam int CTRL_DIFF = 1;
   localparam int CTRL_KIND = 2;

   localparam int ST_BUSY  = 0;
   localparam int ST_ERR   = 1;
   localparam int ST_EQUAL = 2;
   localparam int ST_DUP   = 3;
   localparam int ST_ABORT = 4;
   localparam int ST_MON   = 5;

   // ----------------------------------------------------------------
   // Address areas and unit layout
   // ----------------------------------------------------------------
   localparam logic [15:0] BASIC_LO   = 16'h0000;
   localparam logic [15:0] BASIC_HI   = 16'h03E7;
   localparam logic [15:0] SPEC_LO    = 16'h07D0;
   localparam logic [15:0] SPEC_HI    = 16'h0B8F;
   localparam logic [15:0] UNIT_WORDS = 16'h000A;
   localparam logic [15:0] UNIT_MAX   = 16'h005F;
   localparam int          UNIT_CNT   = 96;

   localparam logic [1:0] AREA_NONE  = 2'h0;
   localparam logic [1:0] AREA_BASIC = 2'h1;
   localparam logic [1:0] AREA_SPEC  = 2'h2;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam longint CLK_HZ       = 100000000;
   localparam longint MON_TIME_S   = 11;
   localparam longint MON_CYCLES   = MON_TIME_S * CLK_HZ;
   localparam int     RESET_STATUS = 0;

   // ----------------------------------------------------------------
   // States and carriers
   // ----------------------------------------------------------------
   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_LOOK = 6'h02,
      S_IMRD = 6'h04,
      S_XFER = 6'h08,
      S_IMWR = 6'h10,
      S_DONE = 6'h20
   } irw_state_e;

   typedef struct packed {
      logic        present;
      logic        first;
      logic        tbl_err;
      logic        slave_rack;
      logic        cyc_en;
      logic [15:0] len;
   } irw_desc_s;

   typedef struct packed {
      logic        dm;
      logic [15:0] addr;
   } irw_word_s;

endpackage : irw_pkg

// ==== design/irw_refresh.sv ====
/*
 Immediate I/O word refresh engine with APB registers. Software writes
 the operands, then writes CTRL to execute the command once.
 Assumes a combinational unit table answering the lookup address in the
 same cycle, a CPU image memory with one-cycle read latency, and an I/O
 bus that answers each request with ack or bus error.
*/
`timescale 1ns/100ps
`default_nettype none
module irw_refresh #(
   parameter longint MON_CYC   = irw_pkg::MON_CYCLES,
   parameter int     DM_WORDS  = 100
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   output logic [15:0]           lk_addr,
   input  wire irw_pkg::irw_desc_s lk_desc,
   output logic                  img_re,
   output logic                  img_we,
   output irw_pkg::irw_word_s    img_addr,
   output logic [15:0]           img_wdata,
   input  wire logic [15:0]      img_rdata,
   output logic                  io_req,
   output irw_pkg::irw_word_s    io_addr,
   output logic [15:0]           io_wdata,
   input  wire logic             io_ack,
   input  wire logic [15:0]      io_rdata,
   input  wire logic             io_bus_err,
   input  wire logic             irq_ctx,
   input  wire logic             sync_fail,
   input  wire logic             cyc_ref_active,
   input  wire logic [6:0]       cyc_ref_unit,
   input  wire logic             intel_acc,
   input  wire logic [6:0]       intel_unit,
   input  wire logic             scan_start,
   input  wire logic [95:0]      cyc_dis,
   output logic                  unit_error_indicator
);

   // ----------------------------------------------------------------
   // Checks and helpers
   // ----------------------------------------------------------------
   initial begin
      if (MON_CYC < 2 || MON_CYC > 64'h7FFFFFFF || DM_WORDS < 1 || DM_WORDS > 1000) begin
         $error("irw_refresh: unsupported parameter value");
      end
   end

   localparam logic [31:0] MON_LIM = 32'(MON_CYC - 1);
   localparam logic [15:0] DM_LEN  = 16'(DM_WORDS);

   function automatic logic [1:0] area_of(input logic [15:0] a);
      if (a <= irw_pkg::BASIC_HI) begin
         area_of = irw_pkg::AREA_BASIC;
      end else if (a >= irw_pkg::SPEC_LO && a <= irw_pkg::SPEC_HI) begin
         area_of = irw_pkg::AREA_SPEC;
      end else begin
         area_of = irw_pkg::AREA_NONE;
      end
   endfunction

   function automatic logic [6:0] unit_of(input logic [15:0] a);
      logic [15:0] d;
      d = (a - irw_pkg::SPEC_LO) / irw_pkg::UNIT_WORDS;
      unit_of = d[6:0];
   endfunction

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   irw_pkg::irw_state_e state_ff;
   logic [15:0] start_ff, end_ff, unit_num_ff, cur_ff, left_ff, dm_base_ff;
   logic        kind_ff, prev_cond_ff, in_dm_ff, sent_ff, cur_spec_ff;
   logic [6:0]  cur_unit_ff;
   logic        err_ff, equal_ff, dup_ff, abort_ff;
   logic [95:0] touched_ff, done_ff;
   logic [31:0] mon_cnt_ff;
   logic        mon_exp_ff;
   logic [15:0] io_word_ff;

   wire acc    = psel & penable & pready;
   wire wr_acc = acc & pwrite;
   wire busy   = (state_ff != irw_pkg::S_IDLE);
   wire exec   = wr_acc & (paddr == irw_pkg::OFS_CTRL) & ~busy;
   wire run    = pwdata[irw_pkg::CTRL_COND] &
                 (~pwdata[irw_pkg::CTRL_DIFF] | ~prev_cond_ff);

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         if (psel & ~penable) begin
            unique case (paddr)
               irw_pkg::OFS_CTRL:   prdata <= {31'h00000000, prev_cond_ff};
               irw_pkg::OFS_START:  prdata <= {16'h0000, start_ff};
               irw_pkg::OFS_END:    prdata <= {16'h0000, end_ff};
               irw_pkg::OFS_UNIT:   prdata <= {16'h0000, unit_num_ff};
               irw_pkg::OFS_STATUS: prdata <= {26'h0000000, unit_error_indicator, abort_ff,
                                               dup_ff, equal_ff, err_ff, busy};
               default:             pslverr <= 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_ff     <= 16'h0000;
         end_ff       <= 16'h0000;
         unit_num_ff  <= 16'h0000;
         kind_ff      <= 1'b0;
         prev_cond_ff <= 1'b0;
      end else if (wr_acc) begin
         if (paddr == irw_pkg::OFS_START) start_ff    <= pwdata[15:0];
         if (paddr == irw_pkg::OFS_END)   end_ff      <= pwdata[15:0];
         if (paddr == irw_pkg::OFS_UNIT)  unit_num_ff <= pwdata[15:0];
         if (exec) begin
            kind_ff      <= pwdata[irw_pkg::CTRL_KIND];
            prev_cond_ff <= pwdata[irw_pkg::CTRL_COND];
         end
      end
   end

   // ----------------------------------------------------------------
   // Refresh sequencer
   // ----------------------------------------------------------------
   wire irw_pkg::irw_desc_s d = lk_desc;
   wire startable = d.present & d.first & ~d.tbl_err & ~d.slave_rack;
   wire unit_base = kind_ff ? 1'b1 : (area_of(cur_ff) == irw_pkg::AREA_SPEC);
   wire collide   = kind_ff & cyc_ref_active & (cyc_ref_unit == unit_num_ff[6:0]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff    <= irw_pkg::S_IDLE;
         cur_ff      <= 16'h0000;
         left_ff     <= 16'h0000;
         dm_base_ff  <= 16'h0000;
         in_dm_ff    <= 1'b0;
         sent_ff     <= 1'b0;
         cur_spec_ff <= 1'b0;
         cur_unit_ff <= 7'h00;
         lk_addr     <= 16'h0000;
         img_re      <= 1'b0;
         img_we      <= 1'b0;
         img_addr    <= '0;
         img_wdata   <= 16'h0000;
         io_req      <= 1'b0;
         io_addr     <= '0;
         io_wdata    <= 16'h0000;
         io_word_ff  <= 16'h0000;
         err_ff      <= 1'b0;
         equal_ff    <= 1'b0;
      end else begin
         img_re <= 1'b0;
         img_we <= 1'b0;
         io_req <= 1'b0;
         unique case (state_ff)
            irw_pkg::S_IDLE: begin
               if (exec && run && !pwdata[irw_pkg::CTRL_KIND]) begin
                  if (start_ff > end_ff ||
                      area_of(start_ff) != area_of(end_ff) ||
                      area_of(start_ff) == irw_pkg::AREA_NONE) begin
                     err_ff <= 1'b1;
                  end else begin
                     err_ff   <= 1'b0;
                     cur_ff   <= start_ff;
                     lk_addr  <= start_ff;
                     state_ff <= irw_pkg::S_LOOK;
                  end
               end else if (exec && run) begin
                  if (unit_num_ff > irw_pkg::UNIT_MAX) begin
                     err_ff <= 1'b1;
                  end else begin
                     err_ff   <= 1'b0;
                     cur_ff   <= 16'(irw_pkg::SPEC_LO + unit_num_ff * irw_pkg::UNIT_WORDS);
                     lk_addr  <= 16'(irw_pkg::SPEC_LO + unit_num_ff * irw_pkg::UNIT_WORDS);
                     state_ff <= irw_pkg::S_LOOK;
                  end
               end
            end
            irw_pkg::S_LOOK: begin
               in_dm_ff    <= 1'b0;
               cur_spec_ff <= unit_base;
               cur_unit_ff <= unit_of(cur_ff);
               dm_base_ff  <= 16'(unit_of(cur_ff) * DM_LEN);
               if (kind_ff) begin
                  if (!(d.present && d.first) || d.tbl_err || d.slave_rack) begin
                     err_ff   <= 1'b1;
                     equal_ff <= 1'b0;
                     state_ff <= irw_pkg::S_IDLE;
                  end else if (collide) begin
                     equal_ff <= 1'b0;
                     state_ff <= irw_pkg::S_IDLE;
                  end else begin
                     left_ff  <= irw_pkg::UNIT_WORDS;
                     state_ff <= irw_pkg::S_IMRD;
                  end
               end else if (cur_ff > end_ff) begin
                  state_ff <= irw_pkg::S_DONE;
               end else if (startable) begin
                  left_ff  <= unit_base ? irw_pkg::UNIT_WORDS : d.len;
                  state_ff <= irw_pkg::S_IMRD;
               end else begin
                  cur_ff  <= cur_ff + 16'h0001;
                  lk_addr <= cur_ff + 16'h0001;
               end
            end
            irw_pkg::S_IMRD: begin
               img_re           <= 1'b1;
               img_addr         <= '{dm: in_dm_ff, addr: in_dm_ff ? dm_base_ff : cur_ff};
               io_word_ff       <= in_dm_ff ? dm_base_ff : cur_ff;
               sent_ff          <= 1'b0;
               state_ff         <= irw_pkg::S_XFER;
            end
            irw_pkg::S_XFER: begin
               if (io_bus_err || (sync_fail && !kind_ff)) begin
                  err_ff   <= sync_fail & ~kind_ff;
                  equal_ff <= 1'b0;
                  state_ff <= irw_pkg::S_IDLE;
               end else if (!sent_ff && !img_re) begin
                  sent_ff  <= 1'b1;
                  io_req   <= 1'b1;
                  io_addr  <= '{dm: in_dm_ff, addr: io_word_ff};
                  io_wdata <= img_rdata;
               end else if (sent_ff && io_ack) begin
                  img_we    <= 1'b1;
                  img_wdata <= io_rdata;
                  state_ff  <= irw_pkg::S_IMWR;
               end
            end
            irw_pkg::S_IMWR: begin
               if (in_dm_ff) begin
                  dm_base_ff <= dm_base_ff + 16'h0001;
               end else begin
                  cur_ff <= cur_ff + 16'h0001;
               end
               left_ff <= left_ff - 16'h0001;
               if (left_ff != 16'h0001) begin
                  state_ff <= irw_pkg::S_IMRD;
               end else if (cur_spec_ff && !in_dm_ff) begin
                  in_dm_ff <= 1'b1;
                  left_ff  <= DM_LEN;
                  state_ff <= irw_pkg::S_IMRD;
               end else if (kind_ff) begin
                  equal_ff <= 1'b1;
                  state_ff <= irw_pkg::S_IDLE;
               end else begin
                  lk_addr  <= in_dm_ff ? cur_ff : cur_ff + 16'h0001;
                  state_ff <= irw_pkg::S_LOOK;
               end
            end
            irw_pkg::S_DONE: begin
               state_ff <= irw_pkg::S_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Duplicate refresh tracking and bus-error abort flag
   // ----------------------------------------------------------------
   wire unit_go = (state_ff == irw_pkg::S_LOOK) & unit_base &
                  (kind_ff ? (d.present & d.first & ~d.tbl_err & ~d.slave_rack & ~collide)
                           : (startable & (cur_ff <= end_ff)));
   wire [6:0] go_unit = unit_of(cur_ff);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         touched_ff <= 96'h0;
      end else begin
         touched_ff <= scan_start ? 96'h0 : touched_ff;
         if (unit_go) touched_ff[go_unit] <= 1'b1;
         if (intel_acc) touched_ff[intel_unit] <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dup_ff   <= 1'b0;
         abort_ff <= 1'b0;
      end else begin
         if (wr_acc && paddr == irw_pkg::OFS_STATUS && pwdata[irw_pkg::ST_DUP]) dup_ff <= 1'b0;
         if (unit_go && irq_ctx && d.cyc_en && !cyc_dis[go_unit] && touched_ff[go_unit]) begin
            dup_ff <= 1'b1;
         end
         if (wr_acc && paddr == irw_pkg::OFS_STATUS && pwdata[irw_pkg::ST_ABORT]) begin
            abort_ff <= 1'b0;
         end
         if (state_ff == irw_pkg::S_XFER && io_bus_err) abort_ff <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Start-up monitor for units with cyclic refresh off
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_ff    <= 96'h0;
         mon_cnt_ff <= 32'h00000000;
         mon_exp_ff <= 1'b0;
         unit_error_indicator <= 1'b0;
      end else begin
         if (unit_go) done_ff[go_unit] <= 1'b1;
         if (!mon_exp_ff) begin
            mon_cnt_ff <= mon_cnt_ff + 32'h00000001;
            if (mon_cnt_ff == MON_LIM) begin
               mon_exp_ff <= 1'b1;
               unit_error_indicator <= |(cyc_dis & ~done_ff);
            end
         end
      end
   end

endmodule // irw_refresh
`default_nettype wire

// ==== tb/irw_refresh_asserts.sv ====
/* Port checker for irw_refresh.
   Bound to each irw_refresh instance; sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module irw_refresh_asserts #(
   parameter longint MON_CYC = 200
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        img_re,
   input wire logic        img_we,
   input wire logic [15:0] img_wdata,
   input wire logic [15:0] img_rdata,
   input wire logic        io_req,
   input wire logic [15:0] io_wdata,
   input wire logic        io_ack,
   input wire logic [15:0] io_rdata,
   input wire logic        sync_fail,
   input wire logic        unit_error_indicator
);
   // ----------------------------------------------------------------
   // Cycles since reset release
   // ----------------------------------------------------------------
   longint cnt_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_ff <= 0;
      else if (cnt_ff < MON_CYC) cnt_ff <= cnt_ff + 1;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_apb_ready: assert property (psel && !penable |=> pready)
      else $error("access cycle without ready");
   a_unmap_err: assert property (psel && !penable && paddr > 8'h10 |=> pslverr)
      else $error("unmapped access without slave error");
   a_unmap_zero: assert property (psel && !penable && !pwrite && paddr > 8'h10 |=> prdata == 0)
      else $error("unmapped read not zero");
   a_read_to_req: assert property (img_re && !sync_fail |-> ##2 io_req)
      else $error("image read not followed by transfer");
   a_out_word: assert property (io_req |-> io_wdata == $past(img_rdata))
      else $error("output word differs from image");
   a_in_word: assert property (io_ack |=> img_we && img_wdata == $past(io_rdata))
      else $error("input word not written back");
   a_one_word: assert property (io_req |=> !io_req [*4])
      else $error("second transfer too soon");
   a_mon_early: assert property (cnt_ff < MON_CYC - 1 |-> !unit_error_indicator)
      else $error("monitor error before timeout");
   c_xfer: cover property (io_req ##1 !io_ack);
   c_wback: cover property (img_we);
   c_mon: cover property (unit_error_indicator);
endmodule // irw_refresh_asserts
bind irw_refresh irw_refresh_asserts #(.MON_CYC(MON_CYC)) irw_refresh_asserts_inst (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
   .img_re, .img_we, .img_wdata, .img_rdata, .io_req, .io_wdata, .io_ack, .io_rdata,
   .sync_fail, .unit_error_indicator
);
`default_nettype wire

// ==== tb/irw_units.sv ====
/* Rack model: unit table, CPU image and I/O bus responder.
   Assumes the refresh engine holds io_wdata while a word is out. */
`timescale 1ns/100ps
`default_nettype none
module irw_units (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               slow,
   input  wire logic               bad_bus,
   input  wire logic [15:0]        lk_addr,
   output irw_pkg::irw_desc_s      lk_desc,
   input  wire logic               img_re,
   input  wire irw_pkg::irw_word_s img_addr,
   output logic [15:0]             img_rdata,
   input  wire logic               io_req,
   input  wire logic [15:0]        io_wdata,
   output logic                    io_ack,
   output logic [15:0]             io_rdata,
   output logic                    io_bus_err
);
   logic [2:0] wait_ff;
   function automatic irw_pkg::irw_desc_s dsc(logic f, logic t, logic r, logic [15:0] n);
      return '{1'b1, f, t, r, 1'b1, n};
   endfunction
   // ----------------------------------------------------------------
   // Mounted units
   // ----------------------------------------------------------------
   always_comb begin
      lk_desc = '0;
      case (lk_addr)
         16'h000F: lk_desc = dsc(1'b1, 1'b0, 1'b0, 16'h0002);
         16'h0010: lk_desc = dsc(1'b0, 1'b0, 1'b0, 16'h0002);
         16'h0014: lk_desc = dsc(1'b1, 1'b1, 1'b0, 16'h0001);
         16'h0015: lk_desc = dsc(1'b1, 1'b0, 1'b1, 16'h0001);
         default: begin
            if (lk_addr >= 16'h07D0 && lk_addr <= 16'h07D9) begin
               lk_desc = dsc(lk_addr == 16'h07D0, 1'b0, 1'b0, 16'h000A);
            end
         end
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_ff    <= 3'h0;
         io_ack     <= 1'b0;
         io_bus_err <= 1'b0;
         io_rdata   <= 16'h0;
         img_rdata  <= 16'h0;
      end else begin
         img_rdata  <= img_re ? (img_addr.addr ^ 16'h5A5A) : ~img_rdata;
         io_rdata   <= ~io_rdata;
         io_ack     <= 1'b0;
         io_bus_err <= 1'b0;
         if (io_req) wait_ff <= slow ? 3'h4 : 3'h1;
         else if (wait_ff != 3'h0) wait_ff <= wait_ff - 3'h1;
         if (!io_req && wait_ff == 3'h1) begin
            io_ack     <= !bad_bus;
            io_bus_err <= bad_bus;
            io_rdata   <= ~io_wdata ^ 16'h0F0F;
         end
      end
   end
endmodule // irw_units
`default_nettype wire

// ==== tb/irw_refresh_tb.sv ====
/* Self-checking bench for irw_refresh over APB.
   Uses irw_units for the racks; monitor count shortened. */
`timescale 1ns/100ps
`default_nettype none
module irw_refresh_tb;
   localparam int DMW = 4;
   localparam int SPW = 10 + DMW;
   typedef struct packed {
      logic [15:0] s;
      logic [15:0] e;
      logic [2:0]  c;
      logic [7:0]  n;
      logic        r;
   } irw_row_s;
   logic               pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]         paddr = 0;
   logic [31:0]        pwdata = 0, prdata, st;
   logic               pready, pslverr, img_re, img_we, io_req, io_ack, io_bus_err, se;
   logic [15:0]        lk_addr, img_wdata, img_rdata, io_wdata, io_rdata;
   irw_pkg::irw_desc_s lk_desc;
   irw_pkg::irw_word_s img_addr, io_addr;
   logic               irq_ctx = 0, sync_fail = 0, cyc_ref_active = 0;
   logic               intel_acc = 0, scan_start = 0, bad_bus = 0, slow = 1;
   logic [6:0]         cyc_ref_unit = 0, intel_unit = 0;
   logic [95:0]        cyc_dis = 96'h4;
   logic               unit_error_indicator;
   int                 nx = 0, checks = 0, bad_count = 0;
   irw_row_s tbl [14] = '{
      '{16'h000E, 16'h0011, 3'h1, 8'h02, 1'b0},
      '{16'h000E, 16'h0011, 3'h1, 8'h02, 1'b0},
      '{16'h000E, 16'h0011, 3'h3, 8'h00, 1'b0},
      '{16'h000E, 16'h0011, 3'h0, 8'h00, 1'b0},
      '{16'h000E, 16'h0011, 3'h3, 8'h02, 1'b0},
      '{16'h0011, 16'h000E, 3'h1, 8'h00, 1'b1},
      '{16'h000E, 16'h0011, 3'h1, 8'h02, 1'b0},
      '{16'h000F, 16'h07D5, 3'h1, 8'h00, 1'b1},
      '{16'h0014, 16'h0015, 3'h1, 8'h00, 1'b0},
      '{16'h07D0, 16'h07D0, 3'h1, 8'(SPW), 1'b0},
      '{16'h07D1, 16'h07E4, 3'h1, 8'h00, 1'b0},
      '{16'h0000, 16'h0000, 3'h5, 8'(SPW), 1'b0},
      '{16'h0060, 16'h0000, 3'h5, 8'h00, 1'b1},
      '{16'h0001, 16'h0000, 3'h5, 8'h00, 1'b1}
   };
   irw_refresh #(.MON_CYC(3000), .DM_WORDS(DMW)) irw_refresh_inst (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .lk_addr, .lk_desc, .img_re, .img_we, .img_addr, .img_wdata, .img_rdata,
      .io_req, .io_addr, .io_wdata, .io_ack, .io_rdata, .io_bus_err, .irq_ctx, .sync_fail,
      .cyc_ref_active, .cyc_ref_unit, .intel_acc, .intel_unit, .scan_start, .cyc_dis,
      .unit_error_indicator
   );
   irw_units irw_units_inst (
      .pclk, .presetn, .slow, .bad_bus, .lk_addr, .lk_desc, .img_re, .img_addr,
      .img_rdata, .io_req, .io_wdata, .io_ack, .io_rdata, .io_bus_err
   );
   initial begin
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (io_req === 1'b1) nx++;
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      psel   <= 1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      se = pslverr;
      psel    <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic cmd(input logic [15:0] s, input logic [15:0] e, input logic [2:0] c);
      logic [31:0] r;
      apb(1, irw_pkg::OFS_START, {16'h0, s}, r);
      apb(1, irw_pkg::OFS_END, {16'h0, e}, r);
      apb(1, irw_pkg::OFS_UNIT, {16'h0, s}, r);
      nx = 0;
      apb(1, irw_pkg::OFS_CTRL, {29'h0, c}, r);
      repeat (100) begin
         apb(0, irw_pkg::OFS_STATUS, 32'h0, st);
         if (st[irw_pkg::ST_BUSY] === 1'b0) break;
      end
      chk(st[irw_pkg::ST_BUSY], 1'b0);
   endtask
   task automatic pulse(input logic k);
      if (k) intel_acc <= 1;
      else scan_start <= 1;
      @(posedge pclk);
      intel_acc  <= 0;
      scan_start <= 0;
      @(posedge pclk);
   endtask
   task automatic finish_test();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      finish_test();
   end
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      chk(unit_error_indicator, 1'b0);
      apb(1, irw_pkg::OFS_START, 32'h1234, st);
      apb(0, irw_pkg::OFS_START, 32'h0, st);
      chk(st, 32'h1234);
      apb(0, 8'h40, 32'h0, st);
      chk(st, 32'h0);
      chk(se, 1'b1);
      foreach (tbl[i]) begin
         cmd(tbl[i].s, tbl[i].e, tbl[i].c);
         chk(nx, tbl[i].n);
         chk(st[irw_pkg::ST_ERR], tbl[i].r);
      end
      slow <= 0;
      cmd(16'h0, 16'h0, 3'h5);
      chk(st[irw_pkg::ST_EQUAL], 1'b1);
      cyc_ref_active <= 1;
      cmd(16'h0, 16'h0, 3'h5);
      chk(st[irw_pkg::ST_EQUAL], 1'b0);
      chk(nx, 0);
      cyc_ref_active <= 0;
      bad_bus <= 1;
      cmd(16'h07D0, 16'h07D0, 3'h1);
      chk(st[irw_pkg::ST_ABORT], 1'b1);
      chk(nx, 1);
      bad_bus   <= 0;
      sync_fail <= 1;
      cmd(16'h000E, 16'h0011, 3'h1);
      chk(st[irw_pkg::ST_ERR], 1'b1);
      sync_fail <= 0;
      irq_ctx   <= 1;
      pulse(0);
      pulse(1);
      cmd(16'h0, 16'h0, 3'h5);
      chk(st[irw_pkg::ST_DUP], 1'b1);
      cyc_dis[0] <= 1;
      apb(1, irw_pkg::OFS_STATUS, 32'h18, st);
      pulse(0);
      pulse(1);
      cmd(16'h0, 16'h0, 3'h5);
      chk(st[irw_pkg::ST_DUP], 1'b0);
      chk(st[irw_pkg::ST_ABORT], 1'b0);
      repeat (3000) @(posedge pclk);
      chk(unit_error_indicator, 1'b1);
      apb(0, irw_pkg::OFS_STATUS, 32'h0, st);
      chk(st[irw_pkg::ST_MON], 1'b1);
      finish_test();
   end
endmodule // irw_refresh_tb
`default_nettype wire
